// [src/ec_ctrl_pkg.sv]
// Purpose: shared constants and types of the echo canceller state/config block
// Assumes: 250 MHz system clock, 8 kHz audio frames
// Notes: offsets are byte addresses on the plain register port
package ec_ctrl_pkg;

  // Timing
  localparam int CLK_MHZ = 250;
  localparam int FRAME_US = 125;
  localparam int FRAME_CYCLES = FRAME_US * CLK_MHZ;
  localparam int SILENT_FRAMES = 2;

  // Frame latencies
  localparam int RX_DELAY = 2;
  localparam int TX_DELAY = 3;
  localparam int BYP_DELAY = 2;

  // Register offsets
  localparam logic [7:0] OFS_CTRL1_A = 8'h00;
  localparam logic [7:0] OFS_CTRL2_A = 8'h04;
  localparam logic [7:0] OFS_CTRL1_B = 8'h08;
  localparam logic [7:0] OFS_CTRL2_B = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // First control register fields
  localparam int C1_BYPASS = 0;
  localparam int C1_FREEZE = 1;
  localparam int C1_DUAL = 2;
  localparam int C1_CASC = 3;

  // Second control register fields
  localparam int C2_SQUIET = 0;
  localparam int C2_RQUIET = 1;
  localparam int C2_TGOFF = 2;
  localparam int C2_DCOFF = 3;

  localparam logic [3:0] CTRL_RESET = 4'h0;

  // Quiet (positive zero) codes
  localparam logic [15:0] QUIET_LIN = 16'h0000;
  localparam logic [15:0] QUIET_SM = 16'h0080;
  localparam logic [15:0] QUIET_MU = 16'h00ff;
  localparam logic [15:0] QUIET_AL = 16'h00d5;

  typedef enum logic [1:0] {
    FMT_LIN = 2'h0,
    FMT_SM = 2'h1,
    FMT_MU = 2'h2,
    FMT_AL = 2'h3
  } pcm_fmt_e;

  typedef enum logic [3:0] {
    ST_MUTE = 4'h1,
    ST_BYPASS = 4'h2,
    ST_FROZEN = 4'h4,
    ST_ADAPT = 4'h8
  } ec_state_e;

  typedef enum logic [2:0] {
    TOP_PAR = 3'h1,
    TOP_B2B = 3'h2,
    TOP_CASC = 3'h4
  } topo_e;

  typedef enum logic [2:0] {
    PW_SLEEP = 3'h1,
    PW_INIT = 3'h2,
    PW_RUN = 3'h4
  } pwr_e;

endpackage

// [src/echo_canceller_state_config.sv]
// Purpose: state, topology, framing and power control of a dual echo canceller
// Assumes: PCM words, core results and core flags arrive on the system clock
// Notes:
//
// The strobed register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module echo_canceller_state_config #(
  parameter int FRAME_CYC = ec_ctrl_pkg::FRAME_CYCLES,
  parameter int SILENT_CYC = ec_ctrl_pkg::FRAME_CYCLES * ec_ctrl_pkg::SILENT_FRAMES,
  parameter int CNT_W = 17
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic sleepN,
  input wire logic topologySel0,
  input wire logic topologySel1,
  input wire logic stateSelA0,
  input wire logic stateSelA1,
  input wire logic stateSelB0,
  input wire logic stateSelB1,
  input wire logic [1:0] pcmFormat,
  input wire logic framePulseIn,
  input wire logic bitClk,
  input wire logic strobeALine,
  input wire logic [1:0] toneDet,
  input wire logic [1:0] narrowBand,
  input wire logic [1:0][15:0] receiveIn,
  input wire logic [1:0][15:0] sendIn,
  input wire logic [1:0][15:0] cancelled,
  input wire logic [15:0] auxIn,
  output logic [1:0][15:0] receiveOut,
  output logic [1:0][15:0] sendOut,
  output logic receiveOe,
  output logic sendOe,
  output logic [15:0] auxOut,
  input wire logic microTxData,
  input wire logic microTxEn,
  output logic microSerialOut,
  output logic microSerialOe,
  output logic framePulseOut,
  output logic toneFlagA,
  output logic toneFlagB,
  output logic [1:0] adaptEn,
  output logic [1:0] cancelEn,
  output logic [1:0] coeffClear,
  output logic toneGuardEn,
  output logic dcRemovalEn,
  output logic [2:0] topology,
  output logic tdmMode,
  output logic frameTick
);

  if (FRAME_CYC < 2 || SILENT_CYC < 2 || FRAME_CYC >= 2 ** CNT_W || SILENT_CYC >= 2 ** CNT_W) begin : g_bad
    $error("Frame or silence count does not fit the counter");
  end

  // Pin synchroniser
  logic [11:0] pinRaw;
  logic [11:0] meta_q;
  logic [11:0] sync_q;
  logic sleepS;
  logic [1:0] topoS;
  logic [1:0] selAS;
  logic [1:0] selBS;
  logic [1:0] fmtS;
  logic fpS;
  logic bclkS;
  logic stbS;

  assign pinRaw = {sleepN, topologySel0, topologySel1, stateSelA1, stateSelA0,
                   stateSelB1, stateSelB0, pcmFormat, framePulseIn, bitClk, strobeALine};

  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pinRaw;
      sync_q <= meta_q;
    end
  end

  assign {sleepS, topoS, selAS, selBS, fmtS, fpS, bclkS, stbS} = sync_q;

  // Power and init sequencing
  ec_ctrl_pkg::pwr_e pwr_q;
  logic [CNT_W-1:0] initCnt_q;
  logic run;
  logic asleep;

  assign run = (pwr_q == ec_ctrl_pkg::PW_RUN);
  assign asleep = (pwr_q == ec_ctrl_pkg::PW_SLEEP);

  always_ff @(posedge clock) begin
    if (reset) begin
      pwr_q <= ec_ctrl_pkg::PW_SLEEP;
      initCnt_q <= '0;
    end else begin
      case (pwr_q)
        ec_ctrl_pkg::PW_SLEEP: begin
          initCnt_q <= '0;
          if (sleepS) begin
            pwr_q <= ec_ctrl_pkg::PW_INIT;
          end
        end
        ec_ctrl_pkg::PW_INIT: begin
          if (!sleepS) begin
            pwr_q <= ec_ctrl_pkg::PW_SLEEP;
          end else if (initCnt_q == CNT_W'(FRAME_CYC - 1)) begin
            pwr_q <= ec_ctrl_pkg::PW_RUN;
          end else begin
            initCnt_q <= initCnt_q + 1'b1;
          end
        end
        ec_ctrl_pkg::PW_RUN: begin
          if (!sleepS) begin
            pwr_q <= ec_ctrl_pkg::PW_SLEEP;
          end
        end
        default: begin
          pwr_q <= ec_ctrl_pkg::PW_SLEEP;
        end
      endcase
    end
  end

  // Frame boundary and bus style detection
  logic bclkPrev_q;
  logic fpLast_q;
  logic stbPrev_q;
  logic tdm_q;
  logic [CNT_W-1:0] silentCnt_q;
  logic bclkRise;
  logic fpTick;
  logic stbTick;
  logic tick;

  assign bclkRise = bclkS & ~bclkPrev_q;
  assign fpTick = bclkRise & fpS & ~fpLast_q;
  assign stbTick = stbS & ~stbPrev_q;
  assign tick = run & (tdm_q ? fpTick : stbTick);

  always_ff @(posedge clock) begin
    if (reset) begin
      bclkPrev_q <= 1'b0;
      fpLast_q <= 1'b0;
      stbPrev_q <= 1'b0;
    end else if (!asleep) begin
      bclkPrev_q <= bclkS;
      stbPrev_q <= stbS;
      if (bclkRise) begin
        fpLast_q <= fpS;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      tdm_q <= 1'b0;
      silentCnt_q <= '0;
    end else if (!asleep) begin
      if (fpS) begin
        tdm_q <= 1'b1;
        silentCnt_q <= '0;
      end else if (silentCnt_q == CNT_W'(SILENT_CYC - 1)) begin
        tdm_q <= 1'b0;
      end else begin
        silentCnt_q <= silentCnt_q + 1'b1;
      end
    end
  end

  // Control registers, index 0 is canceller A
  logic [1:0][3:0] ctrl1_q;
  logic [1:0][3:0] ctrl2_q;

  always_ff @(posedge clock) begin
    if (reset || !run) begin
      ctrl1_q <= {2{ec_ctrl_pkg::CTRL_RESET}};
      ctrl2_q <= {2{ec_ctrl_pkg::CTRL_RESET}};
    end else if (regWrite) begin
      if (regAddr == ec_ctrl_pkg::OFS_CTRL1_A) begin
        ctrl1_q[0] <= regWdata[3:0];
      end else if (regAddr == ec_ctrl_pkg::OFS_CTRL2_A) begin
        ctrl2_q[0] <= regWdata[3:0];
      end else if (regAddr == ec_ctrl_pkg::OFS_CTRL1_B) begin
        ctrl1_q[1] <= regWdata[3:0];
      end else if (regAddr == ec_ctrl_pkg::OFS_CTRL2_B) begin
        ctrl2_q[1] <= regWdata[3:0];
      end
    end
  end

  // Next configuration from straps or registers
  logic ctrlMode;
  ec_ctrl_pkg::topo_e topoD;
  ec_ctrl_pkg::ec_state_e [1:0] stD;
  logic [1:0] rxQuietD;
  logic [1:0] txQuietD;
  logic guardD;
  logic dcD;
  logic [1:0] muteD;

  function automatic ec_ctrl_pkg::ec_state_e pinState(input logic [1:0] sel);
    ec_ctrl_pkg::ec_state_e s;
    case (sel)
      2'h0: s = ec_ctrl_pkg::ST_MUTE;
      2'h1: s = ec_ctrl_pkg::ST_BYPASS;
      2'h2: s = ec_ctrl_pkg::ST_FROZEN;
      default: s = ec_ctrl_pkg::ST_ADAPT;
    endcase
    return s;
  endfunction

  function automatic ec_ctrl_pkg::ec_state_e regState(input logic [3:0] c1, input logic [3:0] c2);
    ec_ctrl_pkg::ec_state_e s;
    if (c1[ec_ctrl_pkg::C1_BYPASS]) begin
      s = ec_ctrl_pkg::ST_BYPASS;
    end else if (c2[ec_ctrl_pkg::C2_SQUIET] || c2[ec_ctrl_pkg::C2_RQUIET]) begin
      s = ec_ctrl_pkg::ST_MUTE;
    end else if (c1[ec_ctrl_pkg::C1_FREEZE]) begin
      s = ec_ctrl_pkg::ST_FROZEN;
    end else begin
      s = ec_ctrl_pkg::ST_ADAPT;
    end
    return s;
  endfunction

  assign ctrlMode = (topoS == 2'h0);

  always_comb begin
    if (!ctrlMode) begin
      case (topoS)
        2'h1: topoD = ec_ctrl_pkg::TOP_CASC;
        2'h2: topoD = ec_ctrl_pkg::TOP_B2B;
        default: topoD = ec_ctrl_pkg::TOP_PAR;
      endcase
      stD[0] = pinState(selAS);
      stD[1] = pinState(selBS);
      guardD = 1'b1;
      dcD = 1'b1;
    end else begin
      // Both topology bits set is illegal; falls back to parallel
      if (ctrl1_q[0][ec_ctrl_pkg::C1_DUAL] && !ctrl1_q[0][ec_ctrl_pkg::C1_CASC]) begin
        topoD = ec_ctrl_pkg::TOP_B2B;
      end else if (ctrl1_q[0][ec_ctrl_pkg::C1_CASC] && !ctrl1_q[0][ec_ctrl_pkg::C1_DUAL]) begin
        topoD = ec_ctrl_pkg::TOP_CASC;
      end else begin
        topoD = ec_ctrl_pkg::TOP_PAR;
      end
      stD[0] = regState(ctrl1_q[0], ctrl2_q[0]);
      stD[1] = regState(ctrl1_q[1], ctrl2_q[1]);
      guardD = !ctrl2_q[0][ec_ctrl_pkg::C2_TGOFF];
      dcD = !ctrl2_q[0][ec_ctrl_pkg::C2_DCOFF];
    end
    muteD[0] = (stD[0] == ec_ctrl_pkg::ST_MUTE);
    muteD[1] = (stD[1] == ec_ctrl_pkg::ST_MUTE);
    rxQuietD = 2'h0;
    txQuietD = 2'h0;
    case (topoD)
      ec_ctrl_pkg::TOP_B2B: begin
        rxQuietD[0] = muteD[0];
        txQuietD[0] = muteD[1];
      end
      ec_ctrl_pkg::TOP_CASC: begin
        rxQuietD[0] = muteD[0];
      end
      default: begin
        rxQuietD = muteD;
      end
    endcase
  end

  // Settings taken only at a frame boundary
  ec_ctrl_pkg::topo_e topo_q;
  ec_ctrl_pkg::ec_state_e [1:0] st_q;
  logic [1:0] rxQuiet_q;
  logic [1:0] txQuiet_q;
  logic guard_q;
  logic dc_q;
  logic [1:0] clr_q;
  ec_ctrl_pkg::pcm_fmt_e fmt_q;

  always_ff @(posedge clock) begin
    if (reset || !run) begin
      topo_q <= ec_ctrl_pkg::TOP_PAR;
      st_q <= {2{ec_ctrl_pkg::ST_ADAPT}};
      rxQuiet_q <= 2'h0;
      txQuiet_q <= 2'h0;
      guard_q <= 1'b1;
      dc_q <= 1'b1;
      clr_q <= 2'h0;
      fmt_q <= ec_ctrl_pkg::FMT_LIN;
    end else begin
      clr_q <= 2'h0;
      if (tick) begin
        topo_q <= topoD;
        st_q <= stD;
        rxQuiet_q <= rxQuietD;
        txQuiet_q <= txQuietD;
        guard_q <= guardD;
        dc_q <= dcD;
        fmt_q <= ec_ctrl_pkg::pcm_fmt_e'(fmtS);
        for (int c = 0; c < 2; c++) begin
          clr_q[c] <= (stD[c] == ec_ctrl_pkg::ST_BYPASS) && (st_q[c] != ec_ctrl_pkg::ST_BYPASS);
        end
      end
    end
  end

  // Core control outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      adaptEn <= 2'h0;
      cancelEn <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        // Mute, bypass and frozen never adapt; guard hit pauses it
        adaptEn[c] <= run && (st_q[c] == ec_ctrl_pkg::ST_ADAPT)
                      && !(guard_q && narrowBand[c]);
        cancelEn[c] <= run && ((st_q[c] == ec_ctrl_pkg::ST_ADAPT)
                      || (st_q[c] == ec_ctrl_pkg::ST_FROZEN));
      end
    end
  end

  assign coeffClear = clr_q;
  assign toneGuardEn = guard_q;
  assign dcRemovalEn = dc_q;
  assign topology = topo_q;
  assign tdmMode = tdm_q;
  assign frameTick = tick;

  // Quiet code of the active format
  logic [15:0] quiet;

  always_comb begin
    case (fmt_q)
      ec_ctrl_pkg::FMT_SM: quiet = ec_ctrl_pkg::QUIET_SM;
      ec_ctrl_pkg::FMT_MU: quiet = ec_ctrl_pkg::QUIET_MU;
      ec_ctrl_pkg::FMT_AL: quiet = ec_ctrl_pkg::QUIET_AL;
      default: quiet = ec_ctrl_pkg::QUIET_LIN;
    endcase
  end

  // Frame-aligned sample paths, one per canceller
  logic [15:0] rxPipe_q [2][ec_ctrl_pkg::RX_DELAY-1];
  logic [15:0] txPipe_q [2][ec_ctrl_pkg::TX_DELAY-1];
  logic [15:0] byPipe_q [2][ec_ctrl_pkg::BYP_DELAY-1];

  for (genvar c = 0; c < 2; c++) begin : g_path
    logic byp;
    assign byp = (st_q[c] == ec_ctrl_pkg::ST_BYPASS);

    always_ff @(posedge clock) begin
      if (reset) begin
        for (int i = 0; i < ec_ctrl_pkg::RX_DELAY - 1; i++) begin
          rxPipe_q[c][i] <= '0;
        end
        for (int i = 0; i < ec_ctrl_pkg::TX_DELAY - 1; i++) begin
          txPipe_q[c][i] <= '0;
        end
        for (int i = 0; i < ec_ctrl_pkg::BYP_DELAY - 1; i++) begin
          byPipe_q[c][i] <= '0;
        end
        receiveOut[c] <= '0;
        sendOut[c] <= '0;
      end else if (tick) begin
        rxPipe_q[c][0] <= receiveIn[c];
        for (int i = 1; i < ec_ctrl_pkg::RX_DELAY - 1; i++) begin
          rxPipe_q[c][i] <= rxPipe_q[c][i-1];
        end
        txPipe_q[c][0] <= cancelled[c];
        for (int i = 1; i < ec_ctrl_pkg::TX_DELAY - 1; i++) begin
          txPipe_q[c][i] <= txPipe_q[c][i-1];
        end
        byPipe_q[c][0] <= sendIn[c];
        for (int i = 1; i < ec_ctrl_pkg::BYP_DELAY - 1; i++) begin
          byPipe_q[c][i] <= byPipe_q[c][i-1];
        end
        if (rxQuiet_q[c]) begin
          receiveOut[c] <= quiet;
        end else begin
          receiveOut[c] <= rxPipe_q[c][ec_ctrl_pkg::RX_DELAY-2];
        end
        if (txQuiet_q[c]) begin
          sendOut[c] <= quiet;
        end else if (byp) begin
          sendOut[c] <= byPipe_q[c][ec_ctrl_pkg::BYP_DELAY-2];
        end else begin
          sendOut[c] <= txPipe_q[c][ec_ctrl_pkg::TX_DELAY-2];
        end
      end
    end
  end

  // Auxiliary channels, TDM style only
  always_ff @(posedge clock) begin
    if (reset) begin
      auxOut <= '0;
    end else if (tick) begin
      auxOut <= tdm_q ? auxIn : '0;
    end
  end

  // Sleep behaviour of the pins
  assign receiveOe = !asleep;
  assign sendOe = !asleep;
  assign microSerialOe = !asleep && microTxEn;

  always_ff @(posedge clock) begin
    if (reset) begin
      microSerialOut <= 1'b0;
      framePulseOut <= 1'b1;
      toneFlagA <= 1'b1;
      toneFlagB <= 1'b1;
    end else if (asleep) begin
      framePulseOut <= 1'b1;
      toneFlagA <= 1'b1;
      toneFlagB <= 1'b1;
    end else begin
      microSerialOut <= microTxData;
      framePulseOut <= !tick;
      toneFlagA <= !toneDet[0];
      toneFlagB <= !toneDet[1];
    end
  end

  // Register read port, data one cycle after the strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      regRdata <= '0;
    end else if (!regRead) begin
      regRdata <= '0;
    end else if (regAddr == ec_ctrl_pkg::OFS_CTRL1_A) begin
      regRdata <= {28'h0000000, ctrl1_q[0]};
    end else if (regAddr == ec_ctrl_pkg::OFS_CTRL2_A) begin
      regRdata <= {28'h0000000, ctrl2_q[0]};
    end else if (regAddr == ec_ctrl_pkg::OFS_CTRL1_B) begin
      regRdata <= {28'h0000000, ctrl1_q[1]};
    end else if (regAddr == ec_ctrl_pkg::OFS_CTRL2_B) begin
      regRdata <= {28'h0000000, ctrl2_q[1]};
    end else if (regAddr == ec_ctrl_pkg::OFS_STATUS) begin
      regRdata <= {12'h000, toneDet, narrowBand, ctrlMode, pwr_q, tdm_q,
                   topo_q, st_q[1], st_q[0]};
    end else begin
      regRdata <= '0;
    end
  end

endmodule // echo_canceller_state_config

// [verification/ec_ctrl_asserts.sv]
// Purpose: port checks of the echo canceller control
// Assumes: straps change only just after a frame tick
// Notes: bound to every instance of the block
`timescale 1ns/1ns
module ec_ctrl_asserts (
  input wire logic clock,
  input wire logic reset,
  input wire logic regRead,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regRdata,
  input wire logic sleepN,
  input wire logic topologySel0,
  input wire logic topologySel1,
  input wire logic stateSelA0,
  input wire logic stateSelA1,
  input wire logic frameTick,
  input wire logic framePulseOut,
  input wire logic toneFlagA,
  input wire logic toneFlagB,
  input wire logic receiveOe,
  input wire logic sendOe,
  input wire logic tdmMode,
  input wire logic [15:0] auxOut,
  input wire logic [1:0] adaptEn,
  input wire logic [1:0] cancelEn,
  input wire logic [1:0] coeffClear,
  input wire logic [2:0] topology
);
  default clocking @(posedge clock); endclocking
  default disable iff (reset);
  wire [3:0] pins = {topologySel0, topologySel1, stateSelA1, stateSelA0};
  wire strap = topologySel0 | topologySel1;
  wire [2:0] topoExp = topologySel0 ? (topologySel1 ? 3'h1 : 3'h2) : 3'h4;
  // Tick with straps settled past the synchronisers
  sequence steadyTick;
    frameTick && pins == $past(pins, 3);
  endsequence
  a_sleep_outputs: assert property (!sleepN [*6] |=> framePulseOut && toneFlagA && toneFlagB && !receiveOe && !sendOe)
    else $error("outputs active while asleep");
  a_no_tick_asleep: assert property (!sleepN [*4] |-> !frameTick)
    else $error("frame tick while asleep");
  a_wake_init: assert property ($rose(sleepN) |-> !frameTick [*8])
    else $error("frame tick during wake-up init");
  a_read_idle: assert property (!regRead |=> regRdata == 32'h0)
    else $error("read data outside read answer");
  a_read_unmapped: assert property (regRead && regAddr > 8'h10 |=> regRdata == 32'h0)
    else $error("unmapped read not zero");
  a_pulse_follows: assert property (1 |=> framePulseOut == !$past(frameTick))
    else $error("frame pulse out not tied to tick");
  a_mute_halts: assert property (steadyTick ##0 (strap && !stateSelA1 && !stateSelA0) |=> ##1 !adaptEn[0])
    else $error("adaptation while muted");
  a_frozen_cancels: assert property (steadyTick ##0 (strap && stateSelA1 && !stateSelA0) |=> ##1 !adaptEn[0] && cancelEn[0])
    else $error("frozen state wrong");
  a_strap_topology: assert property (steadyTick ##0 strap |=> topology == $past(topoExp))
    else $error("strap topology decode wrong");
  a_clear_pulse: assert property (coeffClear[0] |-> $past(frameTick) ##1 !coeffClear[0])
    else $error("coefficient clear not a tick pulse");
  a_aux_strobed: assert property (frameTick && !tdmMode |=> auxOut == 16'h0)
    else $error("aux data in strobed mode");
  c_tdm_tick: cover property (frameTick && tdmMode);
  c_strobed_tick: cover property (frameTick && !tdmMode);
  c_clear: cover property (coeffClear[0]);
endmodule // ec_ctrl_asserts

bind echo_canceller_state_config ec_ctrl_asserts u_ec_ctrl_asserts (.clock(clock), .reset(reset),
  .regRead(regRead), .regAddr(regAddr), .regRdata(regRdata), .sleepN(sleepN), .topologySel0(topologySel0),
  .topologySel1(topologySel1), .stateSelA0(stateSelA0), .stateSelA1(stateSelA1), .frameTick(frameTick),
  .framePulseOut(framePulseOut), .toneFlagA(toneFlagA), .toneFlagB(toneFlagB), .receiveOe(receiveOe),
  .sendOe(sendOe), .tdmMode(tdmMode), .auxOut(auxOut), .adaptEn(adaptEn), .cancelEn(cancelEn),
  .coeffClear(coeffClear), .topology(topology));

// [verification/ec_pcm_bus_model.sv]
// Purpose: far-side PCM bus: bit clock, framing and sample words
// Assumes: 20 bit periods of 160 ns per frame, 30 when stretched
// Notes: words change only after a frame tick
`timescale 1ns/1ns
module ec_pcm_bus_model (
  input wire logic clock,
  input wire logic frameTick,
  input wire logic tdmOn,
  input wire logic stretch,
  output logic bitClk,
  output logic framePulseIn,
  output logic strobeALine,
  output logic [1:0][15:0] receiveIn,
  output logic [1:0][15:0] sendIn,
  output logic [1:0][15:0] cancelled,
  output logic [15:0] auxIn
);
  logic [11:0] seq_q = 12'h0;
  always @(posedge clock) begin
    if (frameTick) begin
      seq_q <= seq_q + 12'h1;
    end
  end
  assign receiveIn = {4'h2, seq_q, 4'h1, seq_q};
  assign sendIn = {4'h4, seq_q, 4'h3, seq_q};
  assign cancelled = {4'h6, seq_q, 4'h5, seq_q};
  assign auxIn = {4'h7, seq_q};
  initial begin
    bitClk = 1'b0;
    framePulseIn = 1'b0;
    strobeALine = 1'b0;
    #1;
    forever begin
      for (int b = 0; b < (stretch ? 30 : 20); b++) begin
        framePulseIn = tdmOn && b == 0;
        strobeALine = !tdmOn && b < 8;
        // Bit clock stops outside strobes in strobed mode
        #80 bitClk = tdmOn || strobeALine;
        #80 bitClk = 1'b0;
      end
    end
  end
endmodule // ec_pcm_bus_model

// [verification/echo_canceller_state_config_test.sv]
// Purpose: self-checking bench of the echo canceller control
// Assumes: short init and silence counts
// Notes: far side played by ec_pcm_bus_model
`timescale 1ns/1ns
module echo_canceller_state_config_test;
  logic clock, reset, regWrite, regRead, sleepN, topologySel0, topologySel1, sawClear;
  logic stateSelA0, stateSelA1, stateSelB0, stateSelB1, microTxEn, tdmOn, stretch;
  logic [7:0] regAddr;
  logic [31:0] regWdata, regRdata;
  logic [1:0] pcmFormat, toneDet, narrowBand, adaptEn, cancelEn, coeffClear;
  logic [1:0][15:0] receiveIn, sendIn, cancelled, receiveOut, sendOut;
  logic [1:0][15:0] hRx [4], hTx [4], hCan [4];
  logic [15:0] auxIn, auxOut;
  logic [15:0] hAux [4];
  logic [15:0] quiet [4] = '{16'h0000, 16'h0080, 16'h00ff, 16'h00d5};
  logic [7:0] bTab [5] = '{8'h42, 8'h21, 8'h84, 8'h62, 8'h08};
  logic [2:0] topology;
  logic framePulseIn, bitClk, strobeALine, receiveOe, sendOe, microSerialOe, microSerialOut, framePulseOut;
  logic toneFlagA, toneFlagB, toneGuardEn, dcRemovalEn, tdmMode, frameTick;
  int fails, samplesChecked, ticks, cycles;

  echo_canceller_state_config #(.FRAME_CYC(20), .SILENT_CYC(1600)) u_echo_canceller_state_config (
    .clock(clock), .reset(reset), .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite),
    .regRead(regRead), .regRdata(regRdata), .sleepN(sleepN), .topologySel0(topologySel0),
    .topologySel1(topologySel1), .stateSelA0(stateSelA0), .stateSelA1(stateSelA1), .stateSelB0(stateSelB0),
    .stateSelB1(stateSelB1), .pcmFormat(pcmFormat), .framePulseIn(framePulseIn), .bitClk(bitClk),
    .strobeALine(strobeALine), .toneDet(toneDet), .narrowBand(narrowBand), .receiveIn(receiveIn),
    .sendIn(sendIn), .cancelled(cancelled), .auxIn(auxIn), .receiveOut(receiveOut), .sendOut(sendOut),
    .receiveOe(receiveOe), .sendOe(sendOe), .auxOut(auxOut), .microTxData(microTxEn), .microTxEn(microTxEn),
    .microSerialOut(microSerialOut), .microSerialOe(microSerialOe), .framePulseOut(framePulseOut), .toneFlagA(toneFlagA),
    .toneFlagB(toneFlagB), .adaptEn(adaptEn), .cancelEn(cancelEn), .coeffClear(coeffClear),
    .toneGuardEn(toneGuardEn), .dcRemovalEn(dcRemovalEn), .topology(topology), .tdmMode(tdmMode),
    .frameTick(frameTick));

  ec_pcm_bus_model u_ec_pcm_bus_model (.clock(clock), .frameTick(frameTick), .tdmOn(tdmOn), .stretch(stretch),
    .bitClk(bitClk), .framePulseIn(framePulseIn), .strobeALine(strobeALine), .receiveIn(receiveIn),
    .sendIn(sendIn), .cancelled(cancelled), .auxIn(auxIn));

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic giveVerdict();
    $display("checks %0d mismatches %0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(string n, logic [31:0] seen, logic [31:0] e);
    samplesChecked++;
    if (seen !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", n, e, seen);
    end
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge clock);
    regWrite <= 1'b0;
  endtask

  task automatic rdChk(string n, logic [7:0] a, logic [31:0] m, logic [31:0] e);
    @(posedge clock);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge clock);
    regRead <= 1'b0;
    #1 check(n, regRdata & m, e);
  endtask

  task automatic waitTicks(int n);
    repeat (n) @(posedge clock iff frameTick);
    #1;
  endtask

  // Receive, send and aux words taken 1, 2 (1 in bypass) and 0 ticks before the last one
  task automatic chkPaths(logic byp, logic tdm);
    waitTicks(1);
    check("rx", receiveOut, hRx[(ticks + 2) % 4]);
    check("tx", sendOut, byp ? hTx[(ticks + 2) % 4] : hCan[(ticks + 1) % 4]);
    check("aux", auxOut, tdm ? hAux[(ticks + 3) % 4] : 16'h0);
  endtask

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (coeffClear[0]) sawClear <= 1'b1;
    if (frameTick) begin
      hRx[ticks % 4] <= receiveIn;
      hTx[ticks % 4] <= sendIn;
      hCan[ticks % 4] <= cancelled;
      hAux[ticks % 4] <= auxIn;
      ticks <= ticks + 1;
    end
    if (cycles == 90000) begin
      fails++;
      giveVerdict();
    end
  end

  initial begin
    {regWrite, regRead, regAddr, regWdata, pcmFormat, toneDet, narrowBand, microTxEn, stretch, sawClear} = '0;
    {sleepN, topologySel0, topologySel1, stateSelA0, stateSelA1, stateSelB0, stateSelB1, tdmOn} = '1;
    {fails, samplesChecked, ticks, cycles} = '0;
    reset = 1'b1;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    waitTicks(4);
    rdChk("status", 8'h10, '1, 32'h4988);
    check("filters", {toneGuardEn, dcRemovalEn}, 2'b11);
    for (int s = 0; s < 4; s++) begin
      @(posedge clock);
      {stateSelA1, stateSelA0, stateSelB1, stateSelB0} <= {s[1:0], s[1:0]};
      if (s == 0) rdChk("hold", 8'h10, '1, 32'h4988);
      waitTicks(4);
      rdChk("state", 8'h10, '1, 32'h4900 | (32'h11 << s));
      check("adapt", adaptEn, s == 3 ? 2'b11 : 2'b00);
      if (s == 2) check("cancel", cancelEn, 2'b11);
      if (s == 1) check("clear", sawClear, 1'b1);
      if (s != 0) chkPaths(s == 1, 1'b1);
      if (s == 0) for (int f = 0; f < 4; f++) begin
        @(posedge clock);
        pcmFormat <= f[1:0];
        waitTicks(2);
        check("quiet", receiveOut, {2{quiet[f]}});
      end
    end
    {narrowBand, toneDet} <= 4'b0110;
    waitTicks(2);
    check("guard", {adaptEn, cancelEn}, 4'b1011);
    check("toneFlags", {toneFlagA, toneFlagB}, 2'b10);
    @(posedge clock);
    {narrowBand, pcmFormat, toneDet} <= 6'h0;
    for (int i = 0; i < 3; i++) begin
      @(posedge clock);
      {topologySel0, topologySel1} <= 2'(i + 1);
      {stateSelB1, stateSelB0} <= (i == 1) ? 2'b00 : 2'b11;
      waitTicks(4);
      check("topo", topology, 3'h4 >> i);
      if (i == 1) check("b2bTx", sendOut[0], 16'h0);
      if (i == 1) check("b2bRx", receiveOut[0], hRx[(ticks + 2) % 4][0]);
    end
    @(posedge clock);
    {topologySel0, topologySel1} <= 2'b00;
    waitTicks(2);
    for (int i = 0; i < 3; i++) begin
      wr(8'h00, i == 0 ? 32'h0 : 32'h2 << i);
      rdChk("ctrl1", 8'h00, '1, i == 0 ? 32'h0 : 32'h2 << i);
      waitTicks(2);
      check("topoReg", topology, 3'h1 << i);
    end
    wr(8'h04, 32'hc);
    wr(8'h14, 32'hf);
    rdChk("unmapped", 8'h14, '1, 32'h0);
    waitTicks(2);
    check("filtersOff", {toneGuardEn, dcRemovalEn}, 2'b00);
    foreach (bTab[i]) begin
      wr(8'h08, 32'(bTab[i][7:6]));
      wr(8'h0c, 32'(bTab[i][5:4]));
      waitTicks(2);
      rdChk("stateB", 8'h10, 32'hf0, {24'h0, bTab[i][3:0], 4'h0});
      check("adaptB", adaptEn[1], bTab[i][3]);
    end
    @(posedge clock);
    {tdmOn, stretch, topologySel0, topologySel1} <= 4'h7;
    waitTicks(5);
    check("strobed", tdmMode, 1'b0);
    chkPaths(1'b0, 1'b0);
    @(posedge clock);
    sleepN <= 1'b0;
    microTxEn <= 1'b1;
    repeat (20) @(posedge clock);
    check("sleep", {receiveOe, sendOe, microSerialOe, framePulseOut, toneFlagA, toneFlagB}, 6'h7);
    sleepN <= 1'b1;
    repeat (4) @(posedge clock);
    rdChk("init", 8'h10, 32'h7000, 32'h2000);
    repeat (40) @(posedge clock);
    rdChk("run", 8'h10, 32'h7000, 32'h4000);
    rdChk("defaults", 8'h00, '1, 32'h0);
    check("serial", {microSerialOe, microSerialOut}, 2'b11);
    giveVerdict();
  end
endmodule // echo_canceller_state_config_test
